// ==== logic/main_reference_scaler.sv ====
// gain, offset and polarity conditioning of the main analog reference
`timescale 1ns/10ps

// Functional notes
// - polarity code 0 passes both signs, 1 only positive, 2 only negative values.
// - polarity limiting acts on the value after gain and offset, not the raw sample.
// - with a single-sign polarity a value of the wrong sign becomes exactly zero.
// - output equals sample times gain over 100 plus 10 times offset over 100, gain first.
// - offset is a percent of 10 V full scale, held within -400.0..400.0, reset 0.000.
// - gain is a signed percent held within -800.0..800.0, reset 100.0 for unity.
// - the speed/voltage settings apply only while the slave input is open.
// - while the slave input is closed a separate current-reference set applies.
module main_reference_scaler
  import ref_scaler_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                                I_CLK_SYS,
  input  wire logic                                I_NRST,
  input  wire logic                                i_SLAVE_IN,
  input  wire logic                                i_SAMPLE_VALID,
  input  wire logic signed [SAMPLE_W-1:0]          i_SAMPLE,
  input  wire logic                                i_SPEED_SET_LOAD,
  input  wire logic [1:0]                          i_SPEED_REF_POLARITY_SEL,
  input  wire logic signed [ref_scaler_pkg::OFFS_W-1:0] i_SPEED_REF_OFFSET_PCT,
  input  wire logic signed [ref_scaler_pkg::GAIN_W-1:0] i_SPEED_REF_GAIN_PCT,
  input  wire logic                                i_CURR_SET_LOAD,
  input  wire logic [1:0]                          i_CURR_REF_POLARITY_SEL,
  input  wire logic signed [ref_scaler_pkg::OFFS_W-1:0] i_CURR_REF_OFFSET_PCT,
  input  wire logic signed [ref_scaler_pkg::GAIN_W-1:0] i_CURR_REF_GAIN_PCT,
  output logic                                     o_REF_VALID,
  output logic signed [SAMPLE_W-1:0]               o_REF,
  output logic                                     o_CURRENT_MODE,
  output logic                                     o_SATURATED
);
  import ref_scaler_pkg::*;

  localparam int PROD_W = SAMPLE_W + GAIN_W;
  localparam int ACC_W  = PROD_W + 2;
  localparam logic signed [ACC_W-1:0] OUT_MAX = ACC_W'((1 <<< (SAMPLE_W-1)) - 1);
  localparam logic signed [ACC_W-1:0] OUT_MIN = -OUT_MAX - ACC_W'(1);
  localparam logic signed [ACC_W-1:0] DIV_C   = ACC_W'(GAIN_DIV);
  localparam logic signed [ACC_W-1:0] OFFS_C  = ACC_W'(OFFS_TO_MV);

  // refuse sample widths that the limit constants were not sized for;
  // checked while elaborating, so a bad width never reaches simulation
  if (SAMPLE_W < 16 || SAMPLE_W > 24) begin : g_bad_sample_w
    $error("main_reference_scaler: SAMPLE_W must be 16..24");
  end

  // clamp helpers keep loaded settings inside their legal ranges
  function automatic logic signed [GAIN_W-1:0] clamp_gain(input logic signed [GAIN_W-1:0] v);
    if (v > GAIN_MAX) begin
      clamp_gain = GAIN_MAX;
    end else if (v < GAIN_MIN) begin
      clamp_gain = GAIN_MIN;
    end else begin
      clamp_gain = v;
    end
  endfunction : clamp_gain

  function automatic logic signed [OFFS_W-1:0] clamp_offs(input logic signed [OFFS_W-1:0] v);
    if (v > OFFS_MAX) begin
      clamp_offs = OFFS_MAX;
    end else if (v < OFFS_MIN) begin
      clamp_offs = OFFS_MIN;
    end else begin
      clamp_offs = v;
    end
  endfunction : clamp_offs

  // code 3 is not legal; held as bipolar so it never blocks the reference
  function automatic pol_t clean_pol(input logic [1:0] v);
    clean_pol = (v == POL_POS_ONLY) ? POL_POS_ONLY :
                (v == POL_NEG_ONLY) ? POL_NEG_ONLY : POL_BIPOLAR;
  endfunction : clean_pol

  logic                      slave_meta_reg;
  logic                      slave_sync_reg;
  pol_t                      spd_pol_reg;
  logic signed [OFFS_W-1:0]  spd_offs_reg;
  logic signed [GAIN_W-1:0]  spd_gain_reg;
  pol_t                      cur_pol_reg;
  logic signed [OFFS_W-1:0]  cur_offs_reg;
  logic signed [GAIN_W-1:0]  cur_gain_reg;
  logic                      s1_valid_reg;
  logic signed [PROD_W-1:0]  s1_prod_reg;
  logic signed [OFFS_W-1:0]  s1_offs_reg;
  pol_t                      s1_pol_reg;
  pol_t                      sel_pol;
  logic signed [OFFS_W-1:0]  sel_offs;
  logic signed [GAIN_W-1:0]  sel_gain;
  logic signed [ACC_W-1:0]   acc;
  logic signed [ACC_W-1:0]   sat_val;
  logic                      sat_hit;
  logic signed [SAMPLE_W-1:0] ref_next;

  // slave pin crosses in through two flops; only the second is read
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      slave_meta_reg <= 1'b0;
      slave_sync_reg <= 1'b0;
    end else begin
      slave_meta_reg <= i_SLAVE_IN;
      slave_sync_reg <= slave_meta_reg;
    end
  end

  // speed/voltage setting set, defaults give unity bipolar pass-through
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      spd_pol_reg  <= pol_t'(POL_RESET);
      spd_offs_reg <= OFFS_RESET;
      spd_gain_reg <= GAIN_RESET;
    end else if (i_SPEED_SET_LOAD) begin
      spd_pol_reg  <= clean_pol(i_SPEED_REF_POLARITY_SEL);
      spd_offs_reg <= clamp_offs(i_SPEED_REF_OFFSET_PCT);
      spd_gain_reg <= clamp_gain(i_SPEED_REF_GAIN_PCT);
    end
  end

  // current-reference setting set, same defaults and ranges
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cur_pol_reg  <= pol_t'(POL_RESET);
      cur_offs_reg <= OFFS_RESET;
      cur_gain_reg <= GAIN_RESET;
    end else if (i_CURR_SET_LOAD) begin
      cur_pol_reg  <= clean_pol(i_CURR_REF_POLARITY_SEL);
      cur_offs_reg <= clamp_offs(i_CURR_REF_OFFSET_PCT);
      cur_gain_reg <= clamp_gain(i_CURR_REF_GAIN_PCT);
    end
  end

  // set selection by the synchronised slave input
  // in-flight samples keep the set captured when they were taken
  always_comb begin
    // open slave input uses speed set
    // closed slave input uses current set
    sel_pol  = slave_sync_reg ? cur_pol_reg  : spd_pol_reg;
    sel_offs = slave_sync_reg ? cur_offs_reg : spd_offs_reg;
    sel_gain = slave_sync_reg ? cur_gain_reg : spd_gain_reg;
  end

  // stage 1: multiply; settings are frozen with the sample they belong to
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      s1_valid_reg <= 1'b0;
      s1_prod_reg  <= '0;
      s1_offs_reg  <= '0;
      s1_pol_reg   <= POL_BIPOLAR;
    end else begin
      s1_valid_reg <= i_SAMPLE_VALID;
      if (i_SAMPLE_VALID) begin
        // both operands sign-extended so the product is exact
        // gain multiply first
        s1_prod_reg <= PROD_W'(i_SAMPLE) * PROD_W'(sel_gain);
        s1_offs_reg <= sel_offs;
        s1_pol_reg  <= sel_pol;
      end
    end
  end

  // stage 2 arithmetic: scale, add offset, saturate, limit polarity
  always_comb begin
    // product over 1000 plus offset in millivolts
    acc = ACC_W'(s1_prod_reg) / DIV_C + ACC_W'(s1_offs_reg) * OFFS_C;
    sat_hit = (acc > OUT_MAX) || (acc < OUT_MIN);
    if (acc > OUT_MAX) begin
      sat_val = OUT_MAX;
    end else if (acc < OUT_MIN) begin
      sat_val = OUT_MIN;
    end else begin
      sat_val = acc;
    end
    ref_next = sat_val[SAMPLE_W-1:0];
    unique case (s1_pol_reg)
      POL_BIPOLAR: begin
        ref_next = sat_val[SAMPLE_W-1:0];
      end
      POL_POS_ONLY: begin
        if (sat_val < 0) begin
          ref_next = '0;
        end
      end
      POL_NEG_ONLY: begin
        if (sat_val > 0) begin
          ref_next = '0;
        end
      end
      // code 3 is cleaned on load; kept so an unknown code still passes
      default: begin
        ref_next = sat_val[SAMPLE_W-1:0];
      end
    endcase
  end

  // output registers; reference holds between samples
  // status updates only together with the value it describes
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      o_REF_VALID <= 1'b0;
      o_REF       <= '0;
      o_SATURATED <= 1'b0;
    end else begin
      o_REF_VALID <= s1_valid_reg;
      if (s1_valid_reg) begin
        o_REF       <= ref_next;
        o_SATURATED <= sat_hit;
      end
    end
  end

  // which setting set is in force
  assign o_CURRENT_MODE = slave_sync_reg;

endmodule : main_reference_scaler

// ==== pkg/ref_scaler_pkg.sv ====
// constants and types for the main reference scaler
package ref_scaler_pkg;

  // setting widths: gain and offset in tenths of a percent
  localparam int GAIN_W = 14;
  localparam int OFFS_W = 13;

  // gain range and reset value, tenths of a percent (100.0 % = unity)
  localparam logic signed [GAIN_W-1:0] GAIN_MAX   = 14'h1F40;  // 800.0 %
  localparam logic signed [GAIN_W-1:0] GAIN_MIN   = 14'h20C0;  // -800.0 %
  localparam logic signed [GAIN_W-1:0] GAIN_RESET = 14'h03E8;  // 100.0 %

  // offset range and reset value, tenths of a percent of full scale
  localparam logic signed [OFFS_W-1:0] OFFS_MAX   = 13'h0FA0;  // 400.0 %
  localparam logic signed [OFFS_W-1:0] OFFS_MIN   = 13'h1060;  // -400.0 %
  localparam logic signed [OFFS_W-1:0] OFFS_RESET = 13'h0000;  // 0.000 %

  // sample scale: 1 LSB = 1 mV, full scale 10 V = 10000 counts
  localparam int FULL_SCALE_MV = 10000;
  // gain in tenths of a percent: divide the product by 100 * 10
  localparam int GAIN_DIV      = 1000;
  // offset tenths of a percent of 10 V to millivolts
  localparam int OFFS_TO_MV    = FULL_SCALE_MV / GAIN_DIV;

  // polarity codes
  typedef enum logic [1:0] {
    POL_BIPOLAR  = 2'h0,
    POL_POS_ONLY = 2'h1,
    POL_NEG_ONLY = 2'h2
  } pol_t;

  localparam logic [1:0] POL_RESET = 2'h0;

endpackage : ref_scaler_pkg

// ==== tb/ref_scaler_monitor.sv ====
// assertion checker on the scaler ports
`timescale 1ns/10ps
module ref_scaler_monitor #(
  parameter int SAMPLE_W = 16
) (
  input logic                       I_CLK_SYS,
  input logic                       I_NRST,
  input logic                       i_SLAVE_IN,
  input logic                       i_SAMPLE_VALID,
  input logic                       i_SPEED_SET_LOAD,
  input logic [1:0]                 i_SPEED_REF_POLARITY_SEL,
  input logic                       o_REF_VALID,
  input logic signed [SAMPLE_W-1:0] o_REF,
  input logic                       o_CURRENT_MODE,
  input logic                       o_SATURATED
);
  logic [1:0] pol_reg;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  // speed polarity in force; valid only while loads and samples do not overlap
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) pol_reg <= 2'h0;
    else if (i_SPEED_SET_LOAD) pol_reg <= i_SPEED_REF_POLARITY_SEL;
  end
  // slave input held long enough to pass the synchroniser
  sequence slave_closed; i_SLAVE_IN [*4]; endsequence
  sequence slave_open; !i_SLAVE_IN [*4]; endsequence
  lat_valid_a: assert property (i_SAMPLE_VALID |-> ##2 o_REF_VALID)
    else $error("result missing");
  no_extra_a: assert property (!i_SAMPLE_VALID |-> ##2 !o_REF_VALID)
    else $error("result without sample");
  hold_out_a: assert property (!o_REF_VALID |-> $stable(o_REF))
    else $error("output moved while idle");
  pos_only_a: assert property (
    o_REF_VALID && !o_CURRENT_MODE && pol_reg == 2'h1 |-> !o_REF[SAMPLE_W-1])
    else $error("negative value passed");
  neg_only_a: assert property (
    o_REF_VALID && !o_CURRENT_MODE && pol_reg == 2'h2 |-> o_REF[SAMPLE_W-1] || o_REF == '0)
    else $error("positive value passed");
  sat_val_a: assert property (o_SATURATED |-> o_REF == '0 ||
    (o_REF[SAMPLE_W-1] ? ~|o_REF[SAMPLE_W-2:0] : &o_REF[SAMPLE_W-2:0]))
    else $error("clipped value not at a limit");
  mode_on_a: assert property (slave_closed |-> o_CURRENT_MODE)
    else $error("current set not selected");
  mode_off_a: assert property (slave_open |-> !o_CURRENT_MODE)
    else $error("speed set not selected");
endmodule : ref_scaler_monitor

// ==== tb/ana_sampler_model.sv ====
// analog input sampler model feeding the scaler
`timescale 1ns/10ps
module ana_sampler_model (
  input  logic               clk,
  output logic               valid,
  output logic signed [15:0] smp
);
  initial {valid, smp} = 17'h00000;
  // call at a rising edge; idle data is inverted so stale values never match
  task automatic send(input logic signed [15:0] v, input logic hold);
    valid <= 1'b1;
    smp <= v;
    @(posedge clk);
    if (!hold) begin
      valid <= 1'b0;
      smp <= ~v;
    end
  endtask : send
endmodule : ana_sampler_model

// ==== tb/tb_top.sv ====
// self-checking bench for the main reference scaler
`timescale 1ns/10ps
module tb_top;
  import ref_scaler_pkg::*;
  logic I_CLK_SYS, I_NRST, i_SLAVE_IN, i_SAMPLE_VALID, i_SPEED_SET_LOAD, i_CURR_SET_LOAD;
  logic o_REF_VALID, o_CURRENT_MODE, o_SATURATED;
  logic [1:0] i_SPEED_REF_POLARITY_SEL, i_CURR_REF_POLARITY_SEL;
  logic signed [OFFS_W-1:0] i_SPEED_REF_OFFSET_PCT, i_CURR_REF_OFFSET_PCT;
  logic signed [GAIN_W-1:0] i_SPEED_REF_GAIN_PCT, i_CURR_REF_GAIN_PCT;
  logic signed [15:0] i_SAMPLE, o_REF;
  int n_errors = 0;
  int n_tests = 0;
  int eg = 1000, eo = 0, ep = 0;
  ana_sampler_model ana (.clk(I_CLK_SYS), .valid(i_SAMPLE_VALID), .smp(i_SAMPLE));
  main_reference_scaler #(.SAMPLE_W(16)) uut (.*);
  // 250 MHz clock
  initial begin
    I_CLK_SYS = 1'b0;
    forever #2 I_CLK_SYS = ~I_CLK_SYS;
  end
  // expected result: clamp settings, gain first, saturate, then polarity
  function automatic int calc(input int s, output logic sat);
    int g = eg > 8000 ? 8000 : (eg < -8000 ? -8000 : eg);
    int o = eo > 4000 ? 4000 : (eo < -4000 ? -4000 : eo);
    int a = s * g / 1000 + o * 10;
    sat = a > 32767 || a < -32768;
    a = a > 32767 ? 32767 : (a < -32768 ? -32768 : a);
    if ((ep == 1 && a < 0) || (ep == 2 && a > 0)) a = 0;
    return a;
  endfunction : calc
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // both sets see the data; only the chosen strobe loads it
  task automatic ld(input int p, input int o, input int g, input logic cur);
    @(posedge I_CLK_SYS);
    {eg, eo, ep} = {g, o, p};
    {i_SPEED_REF_POLARITY_SEL, i_SPEED_REF_OFFSET_PCT, i_SPEED_REF_GAIN_PCT} <= {p[1:0], o[12:0], g[13:0]};
    {i_CURR_REF_POLARITY_SEL, i_CURR_REF_OFFSET_PCT, i_CURR_REF_GAIN_PCT} <= {p[1:0], o[12:0], g[13:0]};
    {i_SPEED_SET_LOAD, i_CURR_SET_LOAD} <= {!cur, cur};
    @(posedge I_CLK_SYS);
    {i_SPEED_SET_LOAD, i_CURR_SET_LOAD} <= 2'h0;
  endtask : ld
  task automatic chk(input int s);
    int k = 0;
    int e;
    logic es;
    e = calc(s, es);
    @(negedge I_CLK_SYS);
    while (o_REF_VALID !== 1'b1 && k < 8) begin
      @(negedge I_CLK_SYS);
      k++;
    end
    cmp({15'h0000, o_REF_VALID}, 16'h0001);
    cmp(o_REF, e[15:0]);
    cmp({15'h0000, o_SATURATED}, {15'h0000, es});
  endtask : chk
  // two samples back to back
  task automatic pair(input int a, input int b);
    @(posedge I_CLK_SYS);
    ana.send(a[15:0], 1'b1);
    ana.send(b[15:0], 1'b0);
    chk(a);
    chk(b);
  endtask : pair
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // sequence takes under a hundred cycles
  initial begin
    #20000;
    n_errors++;
    stop_test;
  end
  initial begin
    {I_NRST, i_SLAVE_IN, i_SPEED_SET_LOAD, i_CURR_SET_LOAD} = 4'h0;
    {i_SPEED_REF_POLARITY_SEL, i_SPEED_REF_OFFSET_PCT, i_SPEED_REF_GAIN_PCT} = 29'h0;
    {i_CURR_REF_POLARITY_SEL, i_CURR_REF_OFFSET_PCT, i_CURR_REF_GAIN_PCT} = 29'h0;
    repeat (20) @(posedge I_CLK_SYS);
    I_NRST <= 1'b1;
    @(negedge I_CLK_SYS);
    cmp(o_REF, 16'h0000);
    cmp({13'h0000, o_REF_VALID, o_CURRENT_MODE, o_SATURATED}, 16'h0000);
    pair(5000, -7);
    for (int p = 0; p < 4; p++) begin
      ld(p, -200, 1000, 1'b0);
      pair(3000, 1000);
    end
    ld(0, 4095, -8192, 1'b0);
    pair(-1000, 10000);
    ld(0, 0, 1500, 1'b0);
    pair(-7, 7);
    ld(2, 100, 500, 1'b1);
    i_SLAVE_IN <= 1'b1;
    repeat (4) @(posedge I_CLK_SYS);
    pair(3000, -5000);
    cmp({15'h0000, o_CURRENT_MODE}, 16'h0001);
    ld(1, 0, 2000, 1'b0);
    i_SLAVE_IN <= 1'b0;
    repeat (4) @(posedge I_CLK_SYS);
    pair(-3000, 3000);
    cmp({15'h0000, o_CURRENT_MODE}, 16'h0000);
    stop_test;
  end
endmodule : tb_top
bind main_reference_scaler ref_scaler_monitor #(.SAMPLE_W(SAMPLE_W)) mon (.*);
